/* File: hw/pst_loader.sv */
`timescale 1ns/1ps
module pst_loader #(
  parameter int unsigned BUILTIN_ARRAY_SELFTEST_CYCLES = 700000
) (
  // clock and reset
  input  wire logic           clk_i,
  input  wire logic           rst_n_i,
  // serial rom pins and self-test status pin
  input  wire logic           serial_rom_data_in_i,
  output logic                serial_rom_clock_out_o,
  output logic                serial_rom_enable_n_o,
  output logic                selftest_status_out_o,
  // core side inputs
  input  wire logic           fast_load_flag_i,
  input  wire logic           builtin_array_selftest_error_i,
  input  wire logic           instr_retired_i,
  // status and control outputs
  output logic                ictl_selftest_fail_o,
  output logic                core_reset_hold_o,
  output logic                array_init_o,
  output logic                zero_padding_error_o,
  output logic                zero_parity_error_o,
  // instruction cache fill port
  output logic                icache_wr_en_o,
  output logic [9:0]          icache_wr_addr_o,
  output logic [192:0]        icache_wr_data_o,
  // configuration data
  output logic [303:0]        config_data_o,
  output logic                config_valid_o
);

  localparam int unsigned BW = pst_pkg::BLK_BITS;
  localparam int unsigned FW = pst_pkg::BLK_TOTAL;

  pst_pkg::pst_state_e state_reg;
  pst_pkg::pst_state_e state_next;
  logic [19:0]         cyc_reg;
  logic                data_meta_reg;
  logic                data_sync_reg;
  logic                fail_reg;
  logic                status_reg;
  logic                en_n_reg;
  logic                hold_reg;
  logic                init_reg;
  logic [10:0]         bits_reg;
  logic [FW-1:0]       blk_reg;
  logic [11:0]         fcnt_reg;
  logic [303:0]        cfg_reg;
  logic                pad_err_reg;
  logic                par_err_reg;
  logic [9:0]          wr_idx_reg;
  logic                wr_en_reg;
  logic [9:0]          wr_addr_reg;
  logic [192:0]        wr_data_reg;
  logic                cfg_valid_reg;
  logic [10:0]         to_cnt_reg;
  logic [1:0]          pulse_reg;
  logic [1:0]          pulse_next;
  logic                fail_next;
  logic                sclk;
  logic                srom_rise;

  // rom clock divider, runs only during the load phase
  pst_srom_clkgen u_clkgen (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .run_i   (state_reg == pst_pkg::ST_SROM),
    .fast_i  (fast_load_flag_i),
    .sclk_o  (sclk),
    .rise_o  (srom_rise)
  );

  // phase decodes
  wire builtin_array_selftest_done   = (cyc_reg == 20'(BUILTIN_ARRAY_SELFTEST_CYCLES - 1));
  wire result_done = (cyc_reg == 20'(pst_pkg::RESULT_LOW - 1));
  wire take_bit    = srom_rise && (state_reg == pst_pkg::ST_SROM);
  wire load_done   = take_bit && (bits_reg == 11'(pst_pkg::LOAD_BITS - 1));
  wire in_blocks   = (bits_reg < 11'(FW));
  wire in_count    = (bits_reg < 11'(FW + pst_pkg::CNT_BITS));
  wire in_cfg      = (bits_reg < 11'(FW + pst_pkg::CNT_BITS + pst_pkg::CFG_BITS));
  wire lines_zero  = (fcnt_reg[9:0] == 10'h000);
  wire wr_more     = !lines_zero && (wr_idx_reg <= fcnt_reg[9:0]) && (wr_idx_reg < 10'(pst_pkg::NBLK));
  wire [192:0] blk_sel = blk_reg[wr_idx_reg[1:0] * BW +: BW];
  wire timeout_hit = (state_reg == pst_pkg::ST_RUN) && !instr_retired_i &&
                     (to_cnt_reg == 11'(pst_pkg::TIMEOUT - 1));
  wire after_res   = (state_next == pst_pkg::ST_SROM) || (state_next == pst_pkg::ST_WRITE) ||
                     (state_next == pst_pkg::ST_RUN);

  // phase sequencing
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      pst_pkg::ST_IDLE:   state_next = pst_pkg::ST_BUILTIN_ARRAY_SELFTEST;
      pst_pkg::ST_BUILTIN_ARRAY_SELFTEST:   if (builtin_array_selftest_done) state_next = pst_pkg::ST_RESULT;
      pst_pkg::ST_RESULT: if (result_done) state_next = pst_pkg::ST_SROM;
      pst_pkg::ST_SROM:   if (load_done) state_next = pst_pkg::ST_WRITE;
      pst_pkg::ST_WRITE:  if (!wr_more) state_next = pst_pkg::ST_RUN;
      pst_pkg::ST_RUN:    state_next = pst_pkg::ST_RUN;
      default:            state_next = pst_pkg::ST_IDLE;
    endcase
  end

  // status pin: high in test, low in extraction, then result or timeout pulse
  assign fail_next  = fail_reg | ((state_reg == pst_pkg::ST_BUILTIN_ARRAY_SELFTEST) & builtin_array_selftest_error_i);
  assign pulse_next = timeout_hit ? pst_pkg::PULSE_LEN :
                      (pulse_reg != 2'h0) ? pulse_reg - 2'h1 : 2'h0;

  // phase, counters and pin flops
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg  <= pst_pkg::ST_IDLE;
      cyc_reg    <= 20'h00000;
      fail_reg   <= 1'b0;
      status_reg <= 1'b0;
      en_n_reg   <= 1'b1;
      hold_reg   <= 1'b1;
      init_reg   <= 1'b0;
      to_cnt_reg <= 11'h000;
      pulse_reg  <= 2'h0;
    end else begin
      state_reg  <= state_next;
      cyc_reg    <= (state_next != state_reg) ? 20'h00000 : cyc_reg + 20'h00001;
      fail_reg   <= fail_next;
      status_reg <= (state_next == pst_pkg::ST_BUILTIN_ARRAY_SELFTEST) | (after_res & fail_next) |
                    (pulse_next != 2'h0);
      en_n_reg   <= (state_next != pst_pkg::ST_SROM);
      hold_reg   <= (state_next != pst_pkg::ST_RUN);
      init_reg   <= (state_next == pst_pkg::ST_BUILTIN_ARRAY_SELFTEST);
      to_cnt_reg <= (state_reg != pst_pkg::ST_RUN || instr_retired_i || timeout_hit) ?
                    11'h000 : to_cnt_reg + 11'h001;
      pulse_reg  <= pulse_next;
    end
  end

  // data pin synchroniser, first stage read only by the second
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      data_meta_reg <= 1'b0;
      data_sync_reg <= 1'b0;
    end else begin
      data_meta_reg <= serial_rom_data_in_i;
      data_sync_reg <= data_meta_reg;
    end
  end

  // stream deserialiser: blocks, count msb first, config, padding
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      bits_reg    <= 11'h000;
      blk_reg     <= '0;
      fcnt_reg    <= 12'h000;
      cfg_reg     <= '0;
      pad_err_reg <= 1'b0;
    end else if (take_bit) begin
      bits_reg <= bits_reg + 11'h001;
      if (in_blocks) begin
        blk_reg <= {data_sync_reg, blk_reg[FW-1:1]};
      end else if (in_count) begin
        fcnt_reg <= {fcnt_reg[10:0], data_sync_reg};
      end else if (in_cfg) begin
        cfg_reg <= {data_sync_reg, cfg_reg[303:1]};
      end else begin
        pad_err_reg <= pad_err_reg | data_sync_reg;
      end
    end
  end

  // cache fill from low to high address once the count is known
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_idx_reg    <= 10'h000;
      wr_en_reg     <= 1'b0;
      wr_addr_reg   <= 10'h000;
      wr_data_reg   <= '0;
      par_err_reg   <= 1'b0;
      cfg_valid_reg <= 1'b0;
    end else begin
      wr_en_reg     <= (state_reg == pst_pkg::ST_WRITE) && wr_more;
      cfg_valid_reg <= cfg_valid_reg | (state_next == pst_pkg::ST_RUN);
      if ((state_reg == pst_pkg::ST_WRITE) && wr_more) begin
        wr_idx_reg  <= wr_idx_reg + 10'h001;
        wr_addr_reg <= wr_idx_reg;
        wr_data_reg <= blk_sel;
        par_err_reg <= par_err_reg | blk_sel[pst_pkg::PAR_POS0];
      end
    end
  end

  // outputs
  assign serial_rom_clock_out_o = sclk;
  assign serial_rom_enable_n_o  = en_n_reg;
  assign selftest_status_out_o  = status_reg;
  assign ictl_selftest_fail_o   = fail_reg;
  assign core_reset_hold_o      = hold_reg;
  assign array_init_o           = init_reg;
  assign zero_padding_error_o   = pad_err_reg;
  assign zero_parity_error_o    = par_err_reg;
  assign icache_wr_en_o         = wr_en_reg;
  assign icache_wr_addr_o       = wr_addr_reg;
  assign icache_wr_data_o       = wr_data_reg;
  assign config_data_o          = cfg_reg;
  assign config_valid_o         = cfg_valid_reg;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence low16_s;
    !selftest_status_out_o [*8] ##1 !selftest_status_out_o [*8];
  endsequence
  sequence fast_period_s;
    serial_rom_clock_out_o [*8] ##1 !serial_rom_clock_out_o [*8] ##1 serial_rom_clock_out_o;
  endsequence

  reset_low_a: assert property (disable iff (1'b0) !rst_n_i |=> !selftest_status_out_o)
    else $error("status not low after reset");
  builtin_array_selftest_high_a: assert property (state_reg == pst_pkg::ST_BUILTIN_ARRAY_SELFTEST |-> selftest_status_out_o && array_init_o)
    else $error("status or array init low during self-test");
  result_low_a: assert property ($rose(state_reg == pst_pkg::ST_RESULT) |-> low16_s ##1
                                 (state_reg == pst_pkg::ST_SROM))
    else $error("result extraction low interval wrong");
  result_hold_a: assert property (state_reg inside {pst_pkg::ST_SROM, pst_pkg::ST_WRITE} |->
                                  selftest_status_out_o == fail_reg)
    else $error("status does not show self-test result");
  timeout_a: assert property (timeout_hit && !fail_reg |=> selftest_status_out_o [*3] ##1
                              !selftest_status_out_o)
    else $error("timeout pulse not three cycles");
  hold_core_a: assert property (core_reset_hold_o == (state_reg != pst_pkg::ST_RUN))
    else $error("core reset hold wrong");
  fail_bit_a: assert property (state_reg == pst_pkg::ST_SROM |-> ictl_selftest_fail_o == fail_reg &&
                               selftest_status_out_o == ictl_selftest_fail_o)
    else $error("fail bit and status pin disagree");
  no_lines_a: assert property (state_reg == pst_pkg::ST_WRITE && lines_zero |=> !icache_wr_en_o)
    else $error("cache written with zero count");
  rom_enable_a: assert property (state_reg == pst_pkg::ST_SROM |-> !serial_rom_enable_n_o)
    else $error("rom enable not held during load");
  rom_off_a: assert property (state_reg == pst_pkg::ST_RUN |-> serial_rom_enable_n_o && !serial_rom_clock_out_o)
    else $error("rom enable or clock active after load");
  fast_clk_a: assert property ($rose(serial_rom_clock_out_o) && fast_load_flag_i &&
                               bits_reg < 11'(pst_pkg::LOAD_BITS - 2) |-> fast_period_s)
    else $error("fast rom clock period wrong");
  order_a: assert property (state_reg != $past(state_reg) |->
                            state_reg == pst_pkg::ST_BUILTIN_ARRAY_SELFTEST   && $past(state_reg) == pst_pkg::ST_IDLE   ||
                            state_reg == pst_pkg::ST_RESULT && $past(state_reg) == pst_pkg::ST_BUILTIN_ARRAY_SELFTEST   ||
                            state_reg == pst_pkg::ST_SROM   && $past(state_reg) == pst_pkg::ST_RESULT ||
                            state_reg == pst_pkg::ST_WRITE  && $past(state_reg) == pst_pkg::ST_SROM   ||
                            state_reg == pst_pkg::ST_RUN    && $past(state_reg) == pst_pkg::ST_WRITE)
    else $error("phase order violated");
  capture_a: assert property (take_bit |=> bits_reg == $past(bits_reg) + 11'h001)
    else $error("rom clock edge did not capture a bit");

endmodule : pst_loader

/* File: hw/pst_pkg.sv */
package pst_pkg;

  // stream layout
  localparam int unsigned BLK_BITS   = 193;
  localparam int unsigned NBLK       = 4;
  localparam int unsigned CNT_BITS   = 12;
  localparam int unsigned CFG_BITS   = 304;
  localparam int unsigned PAD_BITS   = 63;
  localparam int unsigned BLK_TOTAL  = NBLK * BLK_BITS;
  localparam int unsigned LOAD_BITS  = BLK_TOTAL + CNT_BITS + CFG_BITS + PAD_BITS;
  localparam int unsigned PAR_POS0   = 0;
  localparam int unsigned ICTL_FAIL_BIT = 23;

  // cycle counts
  localparam int unsigned RESULT_LOW = 16;
  localparam int unsigned TIMEOUT    = 2048;
  localparam logic [1:0]  PULSE_LEN  = 2'h3;
  localparam logic [7:0]  DIV_SLOW   = 8'hff;  // last count of a 256-cycle period
  localparam logic [7:0]  DIV_FAST   = 8'h0f;  // last count of a 16-cycle period
  localparam logic [7:0]  HALF_SLOW  = 8'h80;
  localparam logic [7:0]  HALF_FAST  = 8'h08;

  // power-up phases, gray along the path
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_BUILTIN_ARRAY_SELFTEST   = 3'h1,
    ST_RESULT = 3'h3,
    ST_SROM   = 3'h2,
    ST_WRITE  = 3'h6,
    ST_RUN    = 3'h7
  } pst_state_e;

endpackage : pst_pkg

/* File: hw/pst_srom_clkgen.sv */
`timescale 1ns/1ps
module pst_srom_clkgen (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // control
  input  wire logic run_i,
  input  wire logic fast_i,
  // serial clock and capture strobe
  output logic      sclk_o,
  output logic      rise_o
);

  logic [7:0] div_reg;
  logic [7:0] div_next;
  logic       sclk_reg;
  logic       rise_reg;

  // period and half period follow the fast flag
  wire  [7:0] div_last = fast_i ? pst_pkg::DIV_FAST : pst_pkg::DIV_SLOW;
  wire  [7:0] div_half = fast_i ? pst_pkg::HALF_FAST : pst_pkg::HALF_SLOW;
  assign div_next = (div_reg == div_last) ? 8'h00 : div_reg + 8'h01;

  // clock high for the first half, so duty is exactly 50%
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !run_i) begin
      div_reg  <= 8'h00;
      sclk_reg <= 1'b0;
      rise_reg <= 1'b0;
    end else begin
      div_reg  <= div_next;
      sclk_reg <= (div_reg < div_half);
      rise_reg <= (div_reg == 8'h00);
    end
  end

  assign sclk_o = sclk_reg;
  assign rise_o = rise_reg;

endmodule : pst_srom_clkgen

/* File: verification/pst_rom_model.sv */
`timescale 1ns/1ps
// serial rom stand-in: one image bit per rom clock pulse, bit 0 first
module pst_rom_model (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  // rom pins
  input  wire logic          sclk_i,
  input  wire logic          en_n_i,
  input  wire logic [1150:0] image_i,
  output logic               data_o
);
  int unsigned ptr;
  logic [1:0]  hold;
  logic        sclk_q;
  logic        done;
  logic        last;

  // a deselected rom shows no valid bit, so it drives the inverse of its last one
  assign data_o = done ? ~last : image_i[ptr];

  // advance two cycles after each rising rom clock, so data holds past the edge
  always @(posedge clk_i) begin
    sclk_q <= sclk_i;
    last   <= data_o;
    if (!rst_n_i) begin
      ptr  <= 0;
      hold <= 2'h0;
      done <= 1'b0;
    end else begin
      if (sclk_i && !sclk_q) begin
        hold <= 2'h2;
      end else if (hold != 2'h0) begin
        hold <= hold - 2'h1;
      end
      if (hold == 2'h1 && ptr < 1150) begin
        ptr <= ptr + 1;
      end
      if (en_n_i && ptr != 0) begin
        done <= 1'b1;
      end
    end
  end
endmodule : pst_rom_model

/* File: verification/tb_pst_loader.sv */
`timescale 1ns/1ps
module tb_pst_loader;
  localparam int unsigned BISTC = 20;  // short self-test keeps the run small
  logic           clk_i, rst_n_i, rom_data, rom_clk, rom_en_n, status, fast, builtin_array_selftest_err, retired;
  logic           ictl_fail, hold, init, pad_err, par_err, wr_en, cfg_valid;
  logic [9:0]     wr_addr;
  logic [192:0]   wr_data;
  logic [303:0]   cfg_data, cfg;
  logic [319:0]   tmp;
  logic [1150:0]  image;
  logic [192:0]   blk [4];
  logic [9:0]     aq [$];
  logic [192:0]   dq [$];
  int             fails, check_count, n, hits, r, i;

  pst_loader #(.BUILTIN_ARRAY_SELFTEST_CYCLES(BISTC)) i_pst_loader (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .serial_rom_data_in_i(rom_data),
    .serial_rom_clock_out_o(rom_clk), .serial_rom_enable_n_o(rom_en_n), .selftest_status_out_o(status),
    .fast_load_flag_i(fast), .builtin_array_selftest_error_i(builtin_array_selftest_err), .instr_retired_i(retired),
    .ictl_selftest_fail_o(ictl_fail), .core_reset_hold_o(hold), .array_init_o(init),
    .zero_padding_error_o(pad_err), .zero_parity_error_o(par_err), .icache_wr_en_o(wr_en),
    .icache_wr_addr_o(wr_addr), .icache_wr_data_o(wr_data), .config_data_o(cfg_data),
    .config_valid_o(cfg_valid));
  pst_rom_model i_pst_rom_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(rom_clk), .en_n_i(rom_en_n),
    .image_i(image), .data_o(rom_data));

  // 40 MHz cpu clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // collect cache fill writes in arrival order
  always @(negedge clk_i) begin
    if (wr_en === 1'b1) begin
      aq.push_back(wr_addr);
      dq.push_back(wr_data);
    end
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize

  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_num(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_num

  task automatic chk_vec(input logic [303:0] got, input logic [303:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_vec

  // build the rom image, hold reset three cycles, then release
  task automatic reset_run(input logic f, input logic [11:0] c, input logic padbit);
    for (int b = 0; b < 4; b++) for (int k = 0; k < 193; k++) image[b*193+k] = blk[b][k];
    for (int k = 0; k < 12; k++) image[772+k] = c[11-k];
    for (int k = 0; k < 304; k++) image[784+k] = cfg[k];
    for (int k = 0; k < 63; k++) image[1088+k] = (k == 62) ? padbit : 1'b0;
    fast = f;
    rst_n_i = 1'b0;
    repeat (3) @(negedge clk_i);
    aq.delete();
    dq.delete();
    chk_bit(status, 1'b0);
    chk_bit(rom_en_n, 1'b1);
    chk_bit(rom_clk, 1'b0);
    chk_bit(hold, 1'b1);
    rst_n_i = 1'b1;
  endtask : reset_run

  // self-test and result extraction, optionally with an array error mid-test
  task automatic builtin_array_selftest(input logic failx);
    int h = 0;
    int m = 0;
    // the first edge after release already enters self-test
    @(negedge clk_i);
    chk_bit(status, 1'b1);
    chk_bit(init, 1'b1);
    while (status === 1'b1 && h < 1000) begin
      builtin_array_selftest_err = (h == 3) ? failx : 1'b0;
      h++;
      @(negedge clk_i);
    end
    builtin_array_selftest_err = 1'b0;
    chk_num(h, BISTC);
    while (status === 1'b0 && rom_en_n === 1'b1 && m < 100) begin
      m++;
      @(negedge clk_i);
    end
    chk_num(m, 16);
    chk_bit(status, failx);
    chk_bit(ictl_fail, failx);
    chk_bit(rom_en_n, 1'b0);
    chk_bit(hold, 1'b1);
  endtask : builtin_array_selftest

  // follow the rom clock; a slow run stops after three rising edges
  task automatic load(input logic failx, input int per, input int limit, output int rises);
    int k = 0;
    int hi = 0;
    int t1 = 0;
    int t2 = 0;
    logic q = rom_clk;
    rises = 0;
    while (rom_en_n === 1'b0 && k < limit && !(per == 256 && rises == 3)) begin
      @(negedge clk_i);
      k++;
      if (rom_clk === 1'b1 && q === 1'b0) begin
        rises++;
        if (rises == 1) chk_bit(status, failx);
        if (rises == 1) t1 = k;
        if (rises == 2) t2 = k;
      end
      if (rom_clk === 1'b1 && rises == 1) hi++;
      q = rom_clk;
    end
    // cache writes and the run phase land a few cycles after the last bit
    repeat (6) @(negedge clk_i);
    chk_num(t2 - t1, per);
    chk_num(hi, per / 2);
    if (k >= limit) begin
      fails++;
      summarize();
    end
  endtask : load

  initial begin
    rst_n_i = 1'b0;
    fast = 1'b1;
    builtin_array_selftest_err = 1'b0;
    retired = 1'b0;
    image = '0;
    for (int b = 0; b < 4; b++) begin
      tmp = {10{32'h1f2e_3d4c}} >> (b * 7);
      blk[b] = tmp[192:0];
    end
    tmp = {10{32'ha5c3_0f96}};
    cfg = tmp[303:0];
    blk[1][0] = 1'b1;  // a written block with its zero parity position set
    // pass, four lines, fast rom clock
    reset_run(1'b1, 12'h003, 1'b0);
    builtin_array_selftest(1'b0);
    load(1'b0, 16, 30000, r);
    chk_num(r, 1151);
    chk_num(aq.size(), 4);
    for (i = 0; i < aq.size(); i++) chk_vec(aq[i], i);
    for (i = 0; i < dq.size(); i++) chk_vec(dq[i], blk[i]);
    chk_vec(cfg_data, cfg);
    chk_bit(cfg_valid, 1'b1);
    chk_bit(hold, 1'b0);
    chk_bit(par_err, 1'b1);
    chk_bit(pad_err, 1'b0);
    // retire just inside the timeout window, then go quiet
    hits = 0;
    for (i = 0; i < 3; i++) begin
      repeat (2040) begin
        @(negedge clk_i);
        if (status !== 1'b0) hits++;
      end
      retired = 1'b1;
      @(negedge clk_i);
      retired = 1'b0;
    end
    chk_num(hits, 0);
    n = 0;
    while (status !== 1'b1 && n < 2100) begin
      @(negedge clk_i);
      n++;
    end
    chk_bit(n >= 2046 && n <= 2050, 1'b1);
    n = 0;
    while (status === 1'b1 && n < 10) begin
      @(negedge clk_i);
      n++;
    end
    chk_num(n, 3);
    // failing self-test, empty fill, stray padding bit
    reset_run(1'b1, 12'h400, 1'b1);
    builtin_array_selftest(1'b1);
    load(1'b1, 16, 30000, r);
    chk_num(aq.size(), 0);
    chk_bit(par_err, 1'b0);
    chk_bit(pad_err, 1'b1);
    chk_bit(status, 1'b1);
    chk_bit(cfg_valid, 1'b1);
    // slow rom clock, cut short after three rising edges
    reset_run(1'b0, 12'h003, 1'b0);
    builtin_array_selftest(1'b0);
    load(1'b0, 256, 2000, r);
    chk_bit(rom_en_n, 1'b0);
    summarize();
  end
endmodule : tb_pst_loader
